/* design/rfb_pkg.sv */
/*
 * Shared constants, carrier types and the FCS step function for the
 * radio frame buffer manager.
 * Assumes a 50 MHz host-side clock and byte-wide frame buffer traffic.
 */
package rfb_pkg;

    // Buffer geometry and frame limits.
    localparam int         BUF_DEPTH     = 128;
    localparam int         ADDR_W        = 7;
    localparam int         PTR_W         = 8;
    localparam logic [7:0] MAX_FRAME_LEN = 8'h7f;
    localparam logic [7:0] MIN_FRAME_LEN = 8'h01;
    localparam logic [6:0] LEN_ADDR      = 7'h00;
    localparam logic [7:0] META_COUNT    = 8'h03;
    localparam logic [7:0] FCS_BYTES     = 8'h02;

    // Reset values and the FCS polynomial.
    localparam logic [7:0]  BYTE_RESET = 8'h00;
    localparam logic [15:0] FCS_INIT   = 16'h0000;
    localparam logic [15:0] FCS_POLY   = 16'h8408;

    // Timing: the underrun flag becomes meaningful a fixed time after receive start.
    localparam int CLK_PERIOD_NS = 20;
    localparam int UR_VALID_NS   = 64000;
    localparam int UR_VALID_CYC  = (UR_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Baseband operations carried across the clock crossing.
    typedef enum logic [1:0] {
        OP_RX_START,
        OP_RX_BYTE,
        OP_RX_META,
        OP_TX_READ
    } rfb_op_t;

    typedef struct packed {
        rfb_op_t           op;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } rfb_req_t;

    typedef struct packed {
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
    } rfb_port_t;

    // One byte of the 16-bit frame check sequence, least significant bit first.
    function automatic logic [15:0] rfb_fcs_step(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        c = crc;
        for (int i = 0; i < 8; i++) begin
            if (c[0] ^ b[i]) begin
                c = (c >> 1) ^ FCS_POLY;
            end else begin
                c = c >> 1;
            end
        end
        return c;
    endfunction

endpackage

/* design/rfb_sync2.sv */
/*
 * Two-flip-flop level synchroniser.
 * Assumes the input is a level that stays put for several destination clocks.
 */
`timescale 1ns/1ns
`default_nettype none

module rfb_sync2 #(
    parameter int W = 1
) (
    // Destination clock.
    input  wire logic         clk,
    // Level from the other domain and its synchronised copy.
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);

    logic [W-1:0] meta_reg;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk) begin
        meta_reg <= d;
        q        <= meta_reg;
    end

endmodule

`default_nettype wire

/* design/rfb_frame_ram.sv */
/*
 * Frame buffer storage with two independent ports, one write each.
 * Assumes both ports are driven from the same clock; reads are asynchronous.
 */
`timescale 1ns/1ns
`default_nettype none

module rfb_frame_ram
    import rfb_pkg::*;
#(
    parameter int DEPTH = BUF_DEPTH
) (
    // Clock and freeze.
    input  wire logic       clk,
    input  wire logic       ce,
    // Host port.
    input  wire rfb_port_t  aPort,
    output logic      [7:0] aRData,
    // Baseband port.
    input  wire rfb_port_t  bPort,
    output logic      [7:0] bRData
);

    logic [7:0] mem [DEPTH];

    // Both ports write in one process; on the same address the baseband wins.
    always_ff @(posedge clk) begin
        if (ce) begin
            if (aPort.we) begin
                mem[aPort.addr] <= aPort.wdata;
            end
            if (bPort.we) begin
                mem[bPort.addr] <= bPort.wdata;
            end
        end
    end

    // Reads are combinational so the caller registers the data once.
    assign aRData = mem[aPort.addr];
    assign bRData = mem[bPort.addr];

endmodule

`default_nettype wire

/* design/rfb_frame_buffer_manager.sv */
/*
 * Frame buffer manager: host port, baseband port on its own clock, data
 * validity, received status append, automatic FCS and underrun detection.
 * Assumes host strobes come from ref_clk logic and baseband strobes from bbClk logic.
 */
`timescale 1ns/1ns
`default_nettype none

module rfb_frame_buffer_manager
    import rfb_pkg::*;
(
    // Host-side clock, reset and freeze.
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       ce,
    // Host buffer access.
    input  wire logic       hostSramMode,
    input  wire logic       hostSessionStart,
    input  wire logic       hostSessionEnd,
    input  wire logic       hostRdStb,
    input  wire logic       hostWrStb,
    input  wire logic [6:0] hostAddr,
    input  wire logic [7:0] hostWData,
    output logic      [7:0] hostRData,
    output logic            hostRValid,
    // Transceiver state and control.
    input  wire logic       trxSleep,
    input  wire logic       busyTx,
    input  wire logic       autoRetryListen,
    input  wire logic       fbProtect,
    input  wire logic       autoFcsEn,
    input  wire logic       underrunAck,
    output logic            bufferUnderrunIrq,
    // Baseband port on its own clock.
    input  wire logic       bbClk,
    input  wire logic       bbRxStart,
    input  wire logic       bbRxByteStb,
    input  wire logic [7:0] bbRxData,
    input  wire logic       bbRxMetaStb,
    input  wire logic [1:0] bbRxMetaIdx,
    input  wire logic       bbTxStart,
    input  wire logic       bbTxNext,
    output logic            bbBusy,
    output logic      [7:0] bbTxData,
    output logic            bbTxValid
);

    // Baseband-side state.
    logic       bbRst;
    logic       bbCe;
    logic       ackSync;
    logic       reqTog_reg;
    logic       ackSeen_reg;
    rfb_req_t   req_reg;
    logic [7:0] txIdx_reg;
    logic [7:0] txLen_reg;
    logic [15:0] crc_reg;
    logic       autoFcsBb;
    logic       ackEdge;
    logic [7:0] txByte;
    logic       isFcsLo;
    logic       isFcsHi;

    // Host-side state.
    logic       reqSync;
    logic       reqSeen_reg;
    logic       ackTog_reg;
    logic [7:0] ackData_reg;
    logic       reqFire;
    rfb_port_t  aPort;
    rfb_port_t  bPort;
    logic [7:0] aRData;
    logic [7:0] bRData;
    logic [PTR_W-1:0] hostPtr_reg;
    logic       hostReadOpen_reg;
    logic       bufValid_reg;
    logic       rxFrame_reg;
    logic       rxActive_reg;
    logic       rxDiscard_reg;
    logic [7:0] frameLen_reg;
    logic [7:0] meta_reg [3];
    logic [PTR_W-1:0] rxWrPtr_reg;
    logic [PTR_W-1:0] txRdPtr_reg;
    logic [11:0] urTimer_reg;
    logic       underrunPending_reg;
    logic       urSet;
    logic       seqMode;
    logic       hostWrOk;
    logic       isMeta;
    logic [7:0] metaIdx;

    // Crossings: reset, freeze and FCS enable into the baseband domain, toggles both ways.
    rfb_sync2 #(.W(3)) uSyncBb (
        .clk (bbClk),
        .d   ({rst, ce, autoFcsEn}),
        .q   ({bbRst, bbCe, autoFcsBb})
    );
    rfb_sync2 #(.W(1)) uSyncAck (
        .clk (bbClk),
        .d   (ackTog_reg),
        .q   (ackSync)
    );
    rfb_sync2 #(.W(1)) uSyncReq (
        .clk (ref_clk),
        .d   (reqTog_reg),
        .q   (reqSync)
    );

    // One request in flight; strobes arriving while busy are dropped, so the
    // baseband must pace itself on bbBusy.
    assign bbBusy  = (reqTog_reg != ackSeen_reg);
    assign ackEdge = (ackSync != ackSeen_reg);
    // The FCS test looks at the address being answered, not the previous index.
    assign isFcsLo = autoFcsBb && txLen_reg >= FCS_BYTES &&
                     {1'b0, req_reg.addr} == txLen_reg - 8'h01;
    assign isFcsHi = autoFcsBb && txLen_reg >= FCS_BYTES &&
                     {1'b0, req_reg.addr} == txLen_reg;

    // Request issue in the baseband domain; the request word stays still until acknowledged.
    always_ff @(posedge bbClk) begin
        if (bbRst) begin
            reqTog_reg  <= 1'b0;
            ackSeen_reg <= 1'b0;
            req_reg     <= '0;
        end else if (bbCe) begin
            if (ackEdge) begin
                ackSeen_reg <= ackSync;
            end
            if (!bbBusy) begin
                if (bbRxStart) begin
                    req_reg    <= '{op: OP_RX_START, addr: LEN_ADDR, data: BYTE_RESET};
                    reqTog_reg <= ~reqTog_reg;
                end else if (bbRxByteStb) begin
                    req_reg    <= '{op: OP_RX_BYTE, addr: req_reg.op == OP_RX_BYTE ?
                                    7'(req_reg.addr + 7'h01) : LEN_ADDR, data: bbRxData};
                    reqTog_reg <= ~reqTog_reg;
                end else if (bbRxMetaStb) begin
                    req_reg    <= '{op: OP_RX_META, addr: {5'h00, bbRxMetaIdx}, data: bbRxData};
                    reqTog_reg <= ~reqTog_reg;
                end else if (bbTxStart) begin
                    req_reg    <= '{op: OP_TX_READ, addr: LEN_ADDR, data: BYTE_RESET};
                    reqTog_reg <= ~reqTog_reg;
                end else if (bbTxNext && txIdx_reg < txLen_reg) begin
                    req_reg    <= '{op: OP_TX_READ, addr: 7'(txIdx_reg + 8'h01), data: BYTE_RESET};
                    reqTog_reg <= ~reqTog_reg;
                end
            end
        end
    end

    // Transmit byte selection: the computed FCS stands in for the last two PSDU bytes.
    always_comb begin
        if (isFcsLo) begin
            txByte = crc_reg[7:0];
        end else if (isFcsHi) begin
            txByte = crc_reg[15:8];
        end else begin
            txByte = ackData_reg;
        end
    end

    // Transmit read results; the index follows the address that was read.
    always_ff @(posedge bbClk) begin
        if (bbRst) begin
            txIdx_reg <= BYTE_RESET;
            txLen_reg <= BYTE_RESET;
            crc_reg   <= FCS_INIT;
            bbTxData  <= BYTE_RESET;
            bbTxValid <= 1'b0;
        end else if (bbCe) begin
            bbTxValid <= 1'b0;
            if (ackEdge && req_reg.op == OP_TX_READ) begin
                txIdx_reg <= {1'b0, req_reg.addr};
                bbTxValid <= 1'b1;
                if (req_reg.addr == LEN_ADDR) begin
                    txLen_reg <= ackData_reg & MAX_FRAME_LEN;
                    crc_reg   <= FCS_INIT;
                    bbTxData  <= ackData_reg;
                end else begin
                    bbTxData <= txByte;
                    if (!isFcsLo && !isFcsHi) begin
                        crc_reg <= rfb_fcs_step(crc_reg, ackData_reg);
                    end
                end
            end
        end
    end

    // Host side: request detection and the storage.
    assign reqFire  = (reqSync != reqSeen_reg);
    assign seqMode  = !hostSramMode;
    assign hostWrOk = hostWrStb && !trxSleep &&
                      (hostSramMode || hostPtr_reg <= PTR_W'(MAX_FRAME_LEN));

    always_comb begin
        aPort.we    = ce && hostWrOk;
        aPort.addr  = hostSramMode ? hostAddr : hostPtr_reg[ADDR_W-1:0];
        aPort.wdata = hostWData;
        bPort.we    = ce && reqFire && req_reg.op == OP_RX_BYTE && !rxDiscard_reg &&
                      !trxSleep;
        bPort.addr  = req_reg.addr;
        bPort.wdata = req_reg.data;
    end

    rfb_frame_ram #(.DEPTH(BUF_DEPTH)) uRam (
        .clk    (ref_clk),
        .ce     (ce),
        .aPort  (aPort),
        .aRData (aRData),
        .bPort  (bPort),
        .bRData (bRData)
    );

    // Appended status bytes follow the frame in sequential reads.
    assign metaIdx = 8'(hostPtr_reg - frameLen_reg - 8'h01);
    assign isMeta  = seqMode && rxFrame_reg && hostPtr_reg > frameLen_reg &&
                     hostPtr_reg <= 8'(frameLen_reg + META_COUNT);

    // Underrun causes, only in sequential access mode.
    always_comb begin
        urSet = 1'b0;
        if (seqMode) begin
            // The discard decision for the new frame is taken now, not from the last frame.
            if (reqFire && req_reg.op == OP_RX_START && hostReadOpen_reg &&
                !(autoRetryListen || fbProtect)) begin
                urSet = 1'b1;
            end
            if (hostRdStb && rxActive_reg && urTimer_reg == 12'h000 &&
                hostPtr_reg >= rxWrPtr_reg) begin
                urSet = 1'b1;
            end
            if (hostWrStb && busyTx && hostPtr_reg <= txRdPtr_reg) begin
                urSet = 1'b1;
            end
            if (hostWrStb && hostPtr_reg > PTR_W'(MAX_FRAME_LEN)) begin
                urSet = 1'b1;
            end
        end
    end

    // Handshake answer: a read result is returned with the acknowledge toggle.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reqSeen_reg <= 1'b0;
            ackTog_reg  <= 1'b0;
            ackData_reg <= BYTE_RESET;
        end else if (ce && reqFire) begin
            reqSeen_reg <= reqSync;
            ackTog_reg  <= ~ackTog_reg;
            ackData_reg <= bufValid_reg ? bRData : BYTE_RESET;
        end
    end

    // Host counter and read data; a session restarts the counter.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hostPtr_reg      <= '0;
            hostReadOpen_reg <= 1'b0;
            hostRData        <= BYTE_RESET;
            hostRValid       <= 1'b0;
        end else if (ce) begin
            hostRValid <= hostRdStb;
            if (hostSessionStart) begin
                hostPtr_reg      <= '0;
                hostReadOpen_reg <= 1'b0;
            end else if (hostSessionEnd) begin
                hostReadOpen_reg <= 1'b0;
            end else if (hostRdStb || hostWrStb) begin
                if (seqMode && hostPtr_reg <= PTR_W'(MAX_FRAME_LEN + META_COUNT)) begin
                    hostPtr_reg <= PTR_W'(hostPtr_reg + 8'h01);
                end
                hostReadOpen_reg <= hostRdStb;
            end
            if (hostRdStb) begin
                if (!bufValid_reg) begin
                    hostRData <= BYTE_RESET;
                end else if (isMeta) begin
                    hostRData <= meta_reg[metaIdx[1:0]];
                end else if (seqMode && hostPtr_reg > PTR_W'(MAX_FRAME_LEN)) begin
                    hostRData <= BYTE_RESET;
                end else begin
                    hostRData <= aRData;
                end
            end
        end
    end

    // Data validity: only writes, reception, sleep or reset change the contents.
    always_ff @(posedge ref_clk) begin
        if (rst || (ce && trxSleep)) begin
            bufValid_reg  <= 1'b0;
            rxFrame_reg   <= 1'b0;
            frameLen_reg  <= BYTE_RESET;
            rxActive_reg  <= 1'b0;
            rxDiscard_reg <= 1'b0;
            rxWrPtr_reg   <= '0;
            for (int i = 0; i < 3; i++) begin
                meta_reg[i] <= BYTE_RESET;
            end
        end else if (ce) begin
            if (aPort.we) begin
                bufValid_reg <= 1'b1;
                rxFrame_reg  <= 1'b0;
                if (aPort.addr == LEN_ADDR) begin
                    frameLen_reg <= hostWData;
                end
            end
            if (reqFire) begin
                unique case (req_reg.op)
                    OP_RX_START: begin
                        rxDiscard_reg <= autoRetryListen || fbProtect;
                        if (!(autoRetryListen || fbProtect)) begin
                            rxActive_reg <= 1'b1;
                            rxWrPtr_reg  <= '0;
                        end
                    end
                    OP_RX_BYTE: begin
                        if (!rxDiscard_reg) begin
                            bufValid_reg <= 1'b1;
                            rxFrame_reg  <= 1'b1;
                            rxWrPtr_reg  <= PTR_W'({1'b0, req_reg.addr} + 8'h01);
                            if (req_reg.addr == LEN_ADDR) begin
                                frameLen_reg <= req_reg.data & MAX_FRAME_LEN;
                            end
                        end
                    end
                    OP_RX_META: begin
                        if (!rxDiscard_reg && req_reg.addr < ADDR_W'(META_COUNT)) begin
                            meta_reg[req_reg.addr[1:0]] <= req_reg.data;
                            rxActive_reg <= 1'b0;
                        end
                    end
                    OP_TX_READ: begin
                    end
                endcase
            end
        end
    end

    // Transmit counter mirror and the hold-off timer after receive start.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            txRdPtr_reg <= '0;
            urTimer_reg <= 12'h000;
        end else if (ce) begin
            if (reqFire && req_reg.op == OP_TX_READ) begin
                txRdPtr_reg <= {1'b0, req_reg.addr};
            end
            if (reqFire && req_reg.op == OP_RX_START) begin
                urTimer_reg <= 12'(UR_VALID_CYC);
            end else if (urTimer_reg != 12'h000) begin
                urTimer_reg <= 12'(urTimer_reg - 12'h001);
            end
        end
    end

    // Sticky underrun; a new cause in the acknowledge cycle wins.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            underrunPending_reg <= 1'b0;
        end else if (ce) begin
            if (urSet) begin
                underrunPending_reg <= 1'b1;
            end else if (underrunAck) begin
                underrunPending_reg <= 1'b0;
            end
        end
    end

    assign bufferUnderrunIrq = underrunPending_reg;

    // Checks.
    property p_ur_set_wins;
        @(posedge ref_clk) disable iff (rst) ce && urSet |=> bufferUnderrunIrq;
    endproperty
    a_ur_set_wins: assert property (p_ur_set_wins) else $error("underrun cause lost");

    property p_ur_sticky;
        @(posedge ref_clk) disable iff (rst)
            bufferUnderrunIrq && !(ce && underrunAck) |=> bufferUnderrunIrq;
    endproperty
    a_ur_sticky: assert property (p_ur_sticky) else $error("underrun dropped unacked");

    property p_sram_quiet;
        @(posedge ref_clk) disable iff (rst)
            $rose(bufferUnderrunIrq) |-> !$past(hostSramMode);
    endproperty
    a_sram_quiet: assert property (p_sram_quiet) else $error("underrun in direct mode");

    property p_sleep_clears;
        @(posedge ref_clk) disable iff (rst)
            (ce && trxSleep) ##1 (ce && hostRdStb) |=> hostRData == BYTE_RESET;
    endproperty
    a_sleep_clears: assert property (p_sleep_clears) else $error("data kept over sleep");

    property p_overflow;
        @(posedge ref_clk) disable iff (rst)
            ce && hostWrStb && seqMode && hostPtr_reg > PTR_W'(MAX_FRAME_LEN)
            |=> bufferUnderrunIrq && bufValid_reg == $past(bufValid_reg);
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow not flagged");

    property p_rx_overrun;
        @(posedge ref_clk) disable iff (rst)
            ce && reqFire && req_reg.op == OP_RX_START && hostReadOpen_reg && seqMode &&
            !(autoRetryListen || fbProtect) |=> bufferUnderrunIrq;
    endproperty
    a_rx_overrun: assert property (p_rx_overrun) else $error("overrun not flagged");

    property p_tx_conflict;
        @(posedge ref_clk) disable iff (rst)
            ce && hostWrStb && seqMode && busyTx && hostPtr_reg <= txRdPtr_reg
            |=> bufferUnderrunIrq;
    endproperty
    a_tx_conflict: assert property (p_tx_conflict) else $error("write conflict missed");

    property p_holdoff;
        @(posedge ref_clk) disable iff (rst)
            ce && reqFire && req_reg.op == OP_RX_START |=> urTimer_reg != 12'h000 [*8];
    endproperty
    a_holdoff: assert property (p_holdoff) else $error("hold-off too short");

    property p_discard;
        @(posedge ref_clk) disable iff (rst)
            reqFire && req_reg.op == OP_RX_BYTE && rxDiscard_reg |-> !bPort.we;
    endproperty
    a_discard: assert property (p_discard) else $error("discarded frame stored");

    property p_fcs_hi;
        @(posedge bbClk) disable iff (bbRst)
            bbCe && ackEdge && req_reg.op == OP_TX_READ && isFcsHi
            |=> bbTxValid && bbTxData == $past(crc_reg[15:8]);
    endproperty
    a_fcs_hi: assert property (p_fcs_hi) else $error("fcs not substituted");

    c_underrun: cover property (@(posedge ref_clk) disable iff (rst) $rose(bufferUnderrunIrq));
    c_meta_read: cover property (@(posedge ref_clk) disable iff (rst) ce && hostRdStb && isMeta);
    c_tx_byte: cover property (@(posedge bbClk) disable iff (bbRst) bbTxValid);

endmodule

`default_nettype wire

/* tb/rfb_host_model.sv */
/* Host-side model: drives the buffer's host strobes.
   Assumes its tasks are called just after a rising host clock edge. */
`timescale 1ns/1ns
`default_nettype none
module rfb_host_model (
    // Host clock and read data.
    input  wire logic       clk,
    input  wire logic [7:0] rData,
    // Strobes and write data toward the buffer.
    output logic            sStart,
    output logic            rdStb,
    output logic            wrStb,
    output logic      [7:0] wData
);
    // All strobes idle from time zero.
    initial begin
        sStart = 1'b0;
        rdStb  = 1'b0;
        wrStb  = 1'b0;
        wData  = 8'h00;
    end
    // Rewinds the host counter.
    task automatic start();
        sStart <= 1'b1;
        @(posedge clk);
        sStart <= 1'b0;
    endtask
    // Back-to-back writes, one byte per host clock with no gap.
    task automatic wrSeq(input logic [7:0] q[$]);
        foreach (q[i]) begin
            wData <= q[i];
            wrStb <= 1'b1;
            @(posedge clk);
        end
        wrStb <= 1'b0;
    endtask
    // One read; the byte is taken at the edge after the strobe.
    task automatic rd(output logic [7:0] b);
        rdStb <= 1'b1;
        @(posedge clk);
        rdStb <= 1'b0;
        @(posedge clk);
        b = rData;
    endtask
endmodule
`default_nettype wire

/* tb/test_rfb_frame_buffer_manager.sv */
/* Bench for the frame buffer manager: host, transmit and receive runs.
   Assumes the package, the design and the host model compile first. */
`timescale 1ns/1ns
`default_nettype none
module test_rfb_frame_buffer_manager;
    logic       ref_clk  = 1'b0;
    logic       bbClk    = 1'b0;
    logic       rst      = 1'b1;
    logic       busyTx   = 1'b0;
    logic       trxSleep = 1'b0;
    logic       urAck    = 1'b0;
    logic       sramMode = 1'b0;
    logic [6:0] hostAddr = 7'h00;
    logic [4:0] bbStb    = 5'h00;
    logic [1:0] bbIdx    = 2'h0;
    logic [7:0] bbData   = 8'h00;
    logic       arl      = 1'b0;
    logic       prot     = 1'b0;
    logic       fcsEn    = 1'b0;
    logic       rValid, txValid;
    logic       sStart, rdStb, wrStb, irq, busy;
    logic [7:0] wData, rData, txData, b;
    logic [7:0] ex[$] = '{8'h02, 8'h44, 8'h55, 8'h66, 8'h67, 8'h68, 8'h00};
    logic [7:0] fr[$] = '{8'h03, 8'h11, 8'h22, 8'h33};
    // The same frame as sent with the check sequence worked out over byte 0x11.
    logic [7:0] fc[$] = '{8'h03, 8'h11, 8'h08, 8'h01};
    logic [7:0] ov[$];
    int         miscompares = 0;
    int         n_checks    = 0;
    int         cyc         = 0;
    // Host clock; the rising baseband edges are offset so they never meet a host edge.
    always #10 ref_clk = ~ref_clk;
    always begin
        #63 bbClk = ~bbClk;
        #62 bbClk = ~bbClk;
    end
    rfb_frame_buffer_manager dut (
        .ref_clk(ref_clk), .rst(rst), .ce(1'b1), .hostSramMode(sramMode),
        .hostSessionStart(sStart), .hostSessionEnd(1'b0), .hostRdStb(rdStb),
        .hostWrStb(wrStb), .hostAddr(hostAddr), .hostWData(wData), .hostRData(rData),
        .hostRValid(rValid), .trxSleep(trxSleep), .busyTx(busyTx), .autoRetryListen(arl),
        .fbProtect(prot), .autoFcsEn(fcsEn), .underrunAck(urAck),
        .bufferUnderrunIrq(irq), .bbClk(bbClk), .bbRxStart(bbStb[0]),
        .bbRxByteStb(bbStb[1]), .bbRxData(bbData), .bbRxMetaStb(bbStb[2]),
        .bbRxMetaIdx(bbIdx), .bbTxStart(bbStb[3]), .bbTxNext(bbStb[4]),
        .bbBusy(busy), .bbTxData(txData), .bbTxValid(txValid));
    rfb_host_model host (.clk(ref_clk), .rData(rData), .sStart(sStart),
        .rdStb(rdStb), .wrStb(wrStb), .wData(wData));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Clears the pending underrun and sees it drop.
    task automatic ackIrq();
        urAck <= 1'b1;
        @(posedge ref_clk);
        urAck <= 1'b0;
        @(posedge ref_clk);
        chk({7'h00, irq}, 8'h00);
    endtask
    // One baseband request; waits, bounded, until the crossing settles it.
    task automatic bbReq(input int k, input logic [7:0] d, input logic [1:0] i);
        @(posedge bbClk);
        bbStb  <= 5'(1 << k);
        bbData <= d;
        bbIdx  <= i;
        @(posedge bbClk);
        bbStb <= 5'h00;
        repeat (40) begin
            @(posedge bbClk);
            if (busy === 1'b0) break;
        end
    endtask
    task automatic finish_test();
        if (miscompares == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Cuts a hung run short; the sequence needs only about a thousand cycles.
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            finish_test();
        end
    end
    // Main sequence; reset is long enough for the baseband domain to see it.
    initial begin
        repeat (40) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (20) @(posedge ref_clk);
        host.start();
        host.wrSeq(fr);
        host.start();
        foreach (fr[i]) begin
            host.rd(b);
            chk(b, fr[i]);
            chk({7'h00, rValid}, 8'h01);
        end
        // Send the frame twice, plain and then with the computed check sequence.
        for (int k = 0; k < 2; k++) begin
            fcsEn <= k[0];
            for (int i = 0; i < 4; i++) begin
                bbReq((i == 0) ? 3 : 4, 8'h00, 2'h0);
                chk(txData, (k == 1) ? fc[i] : fr[i]);
                chk({7'h00, txValid}, 8'h01);
            end
        end
        fcsEn  <= 1'b0;
        busyTx <= 1'b1;
        host.start();
        // Zero fill up to address 6 so the read past the status bytes is defined.
        host.wrSeq('{8'h03, 8'h11, 8'h22, 8'h33, 8'h00, 8'h00, 8'h00});
        @(posedge ref_clk);
        chk({7'h00, irq}, 8'h01);
        busyTx <= 1'b0;
        ackIrq();
        host.rd(b);
        bbReq(0, 8'h00, 2'h0);
        chk({7'h00, irq}, 8'h01);
        for (int i = 0; i < 3; i++) bbReq(1, ex[i], 2'h0);
        for (int i = 0; i < 3; i++) bbReq(2, ex[i + 3], 2'(i));
        chk({7'h00, irq}, 8'h01);
        ackIrq();
        host.start();
        foreach (ex[i]) begin
            host.rd(b);
            chk(b, ex[i]);
        end
        sramMode <= 1'b1;
        host.rd(b);
        chk(b, 8'h02);
        hostAddr <= 7'h02;
        host.rd(b);
        chk(b, 8'h55);
        bbReq(0, 8'h00, 2'h0);
        bbReq(2, 8'h00, 2'h2);
        chk({7'h00, irq}, 8'h00);
        sramMode <= 1'b0;
        host.start();
        for (int i = 0; i < 129; i++) ov.push_back(8'(i + 1));
        host.wrSeq(ov);
        @(posedge ref_clk);
        chk({7'h00, irq}, 8'h01);
        ackIrq();
        host.start();
        host.rd(b);
        chk(b, 8'h01);
        // Protected or acknowledge-listening frames are neither stored nor flagged.
        for (int k = 0; k < 2; k++) begin
            arl  <= (k == 0);
            prot <= (k == 1);
            bbReq(0, 8'h00, 2'h0);
            bbReq(1, 8'h09, 2'h0);
        end
        arl  <= 1'b0;
        prot <= 1'b0;
        chk({7'h00, irq}, 8'h00);
        host.start();
        host.rd(b);
        chk(b, 8'h01);
        trxSleep <= 1'b1;
        repeat (3) @(posedge ref_clk);
        trxSleep <= 1'b0;
        host.start();
        host.rd(b);
        chk(b, 8'h00);
        finish_test();
    end
endmodule
`default_nettype wire
